// File: temp_alarm_defines.svh
// Register addresses, field positions, reset values and timing constants
// ----------------------------------------------------------------------
// Contract
// - Alarm low on limit violation or open diode
// - Alarm pin only pulls low or releases
// - Master reads alert response address on low line
// - Alarm active: answer with address, LSB one
// - Lowest address wins; losers keep alarm
// - Release alarm after answer if condition gone
// - Master repeats alert read while line low
// - Standby bit stops converter, drops running result
// - Register access keeps working in standby
// - One-shot write converts both channels once
// - Limit writes in standby re-evaluate alarm
// - Limit alarm maskable; over-temperature not
// - Alarm when temperature at or below low
// - Alarm when temperature above high limit
// - Over-temperature pin low above its limit
// - One hysteresis, default ten, both channels
// - Hysteresis unsigned count in degree steps
// - Software keeps over-temperature limit above high
// - Sample open-diode at start, set status bit
// - Under-range remote reads as minus 128
// - Minus 128 alarms even at minimum limit
// - One-shot reached by pointer byte; data ignored
// ----------------------------------------------------------------------
`ifndef TEMP_ALARM_DEFINES_SVH
`define TEMP_ALARM_DEFINES_SVH

`define ARA_ADDR          7'h0c
`define RD_LOCAL          8'h00
`define RD_REMOTE         8'h01
`define RD_STATUS         8'h02
`define RD_CONFIG         8'h03
`define RD_LOC_HI         8'h05
`define RD_LOC_LO         8'h06
`define RD_REM_HI         8'h07
`define RD_REM_LO         8'h08
`define WR_CONFIG         8'h09
`define WR_LOC_HI         8'h0b
`define WR_LOC_LO         8'h0c
`define WR_REM_HI         8'h0d
`define WR_REM_LO         8'h0e
`define WR_ONE_SHOT       8'h0f
`define RW_REM_OVERTEMP_FAILSAFE_N      8'h19
`define RW_LOC_OVERTEMP_FAILSAFE_N      8'h20
`define RW_HYST           8'h21
`define RD_MAKER_ID       8'hfe

`define CFG_MASK_BIT      7
`define CFG_STANDBY_BIT   6
`define ST_BUSY_BIT       7
`define ST_LOC_OOR_BIT    4
`define ST_REM_OOR_BIT    3
`define ST_OPEN_BIT       2
`define ST_REM_TH_BIT     1
`define ST_LOC_TH_BIT     0

`define RST_TEMP          8'h00
`define RST_CONFIG        8'h00
`define RST_HI_LIM        8'h55
`define RST_LO_LIM        8'h00
`define RST_OVERTEMP_FAILSAFE_N_LIM     8'h55
`define RST_HYST          8'h0a
`define UNDER_RANGE_CODE  8'h80
`define RELEASED_BYTE     8'hff

`define SYS_CLK_KHZ       20000
`define CONV_PERIOD_MS    50
`define CONV_TIME_MS      10
`define HOST_TIMEOUT      4'h4
`define HOST_ARA_GAP      4'h4

`endif

// File: temp_alarm_pkg.sv
// Shared types of the temperature alarm ends
package temp_alarm_pkg;
    typedef logic signed [7:0] temp_type;
    typedef enum {CONV_IDLE, CONV_BUSY} conv_state_type;
    typedef enum {HOST_IDLE, HOST_WAIT, HOST_GAP} host_state_type;
endpackage

// File: temp_alarm_if.sv
// Link between the temperature monitor and its bus master
interface temp_alarm_if;
    logic       req_valid;
    logic       req_read;
    logic [6:0] req_addr;
    logic [7:0] req_ptr;
    logic       req_has_data;
    logic [7:0] req_data;
    logic       rsp_valid;
    logic       rsp_ack;
    logic [7:0] rsp_data;
    logic [7:0] rsp_bus;
    logic       alert_o;
    logic       alert_oe_n;
    logic       alert_line;
    logic       overtemp_failsafe_n_o;
    logic       overtemp_failsafe_n_oe_n;
    logic       overtemp_failsafe_n_line;

    // Wired-AND resolution; a released driver shows as all ones
    assign rsp_bus = rsp_data;
    assign alert_line = alert_oe_n | alert_o;
    assign overtemp_failsafe_n_line = overtemp_failsafe_n_oe_n | overtemp_failsafe_n_o;

    modport device (
        input  req_valid, req_read, req_addr, req_ptr, req_has_data, req_data, rsp_bus,
        output rsp_valid, rsp_ack, rsp_data, alert_o, alert_oe_n,
        output overtemp_failsafe_n_o, overtemp_failsafe_n_oe_n
    );
    modport host (
        output req_valid, req_read, req_addr, req_ptr, req_has_data, req_data,
        input  rsp_valid, rsp_ack, rsp_bus, alert_line, overtemp_failsafe_n_line
    );
endinterface

// File: temp_limit_check.sv
// Limit and over-temperature comparison of one channel
module temp_limit_check (
    input  wire temp_alarm_pkg::temp_type temp_in,
    input  wire temp_alarm_pkg::temp_type hi_in,
    input  wire temp_alarm_pkg::temp_type lo_in,
    input  wire temp_alarm_pkg::temp_type overtemp_failsafe_n_lim_in,
    input  wire logic [7:0]               hyst_in,
    input  wire logic                     overtemp_failsafe_n_active_in,
    output logic                          out_of_range_out,
    output logic                          overtemp_failsafe_n_next_out
);
    logic signed [9:0] release_lvl;
    logic signed [9:0] temp_wide;
    logic              above_overtemp_failsafe_n;

    // Wide arithmetic so a large hysteresis cannot wrap the release level
    assign release_lvl = 10'(overtemp_failsafe_n_lim_in) - $signed({2'b00, hyst_in});
    assign temp_wide = 10'(temp_in);
    assign above_overtemp_failsafe_n = temp_in > overtemp_failsafe_n_lim_in;
    assign out_of_range_out = (temp_in <= lo_in) || (temp_in > hi_in);
    assign overtemp_failsafe_n_next_out = overtemp_failsafe_n_active_in ? (temp_wide > release_lvl) : above_overtemp_failsafe_n;
endmodule

// File: temp_alarm_device.sv
// Alarm, over-temperature and conversion control of the temperature monitor
`include "temp_alarm_defines.svh"
module temp_alarm_device #(
    parameter logic [6:0]  DEV_ADDR    = 7'h2a,
    // Arbitrary neutral maker code
    parameter logic [7:0]  MAKER_ID    = 8'h5a,
    parameter int unsigned CONV_PERIOD = `CONV_PERIOD_MS * `SYS_CLK_KHZ,
    parameter int unsigned CONV_LEN    = `CONV_TIME_MS * `SYS_CLK_KHZ
) (
    input  wire logic        sys_clk_in,
    input  wire logic        nrst_in,
    temp_alarm_if.device     link,
    input  wire logic [7:0]  adc_local_in,
    input  wire logic [7:0]  adc_remote_in,
    input  wire logic        remote_under_in,
    input  wire logic        diode_open_in,
    output logic             busy_out
);
    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [7:0] loc_s1_q, loc_s2_q, rem_s1_q, rem_s2_q;
    logic       und_s1_q, und_s2_q, open_s1_q, open_s2_q;

    always_ff @(posedge sys_clk_in)
    begin
        loc_s1_q <= adc_local_in;
        loc_s2_q <= loc_s1_q;
        rem_s1_q <= adc_remote_in;
        rem_s2_q <= rem_s1_q;
        und_s1_q <= remote_under_in;
        und_s2_q <= und_s1_q;
        open_s1_q <= diode_open_in;
        open_s2_q <= open_s1_q;
    end

    // ------------------------------------------------------------------
    // Register access decode
    // ------------------------------------------------------------------
    temp_alarm_pkg::temp_type local_q, remote_q, loc_hi_q, loc_lo_q, rem_hi_q, rem_lo_q;
    temp_alarm_pkg::temp_type loc_th_q, rem_th_q;
    logic [7:0] config_q, hyst_q, ptr_q, status;
    logic       open_q, alert_q, th_loc_q, th_rem_q;
    logic       addressed, ara_hit, wr_en, one_shot_wr;
    logic       mask, standby, cond, ara_won;
    logic       loc_oor, rem_oor, th_loc_d, th_rem_d;
    logic       rsp_valid_q, rsp_ack_q, ara_q;
    logic [7:0] rsp_data_q, rd_data;

    assign addressed = link.req_valid && link.req_addr == DEV_ADDR;
    assign ara_hit = link.req_valid && link.req_read && link.req_addr == `ARA_ADDR
                     && alert_q && !mask;
    assign wr_en = addressed && !link.req_read && link.req_has_data;
    // Any data byte works; a pointer-only write to this address works too
    assign one_shot_wr = addressed && !link.req_read && link.req_ptr == `WR_ONE_SHOT;
    assign mask = config_q[`CFG_MASK_BIT];
    assign standby = config_q[`CFG_STANDBY_BIT];

    function automatic logic [7:0] read_mux(input logic [7:0] p);
        case (p)
            `RD_LOCAL:     read_mux = local_q;
            `RD_REMOTE:    read_mux = remote_q;
            `RD_STATUS:    read_mux = status;
            `RD_CONFIG:    read_mux = config_q;
            `RD_LOC_HI:    read_mux = loc_hi_q;
            `RD_LOC_LO:    read_mux = loc_lo_q;
            `RD_REM_HI:    read_mux = rem_hi_q;
            `RD_REM_LO:    read_mux = rem_lo_q;
            `RW_REM_OVERTEMP_FAILSAFE_N: read_mux = rem_th_q;
            `RW_LOC_OVERTEMP_FAILSAFE_N: read_mux = loc_th_q;
            `RW_HYST:      read_mux = hyst_q;
            `RD_MAKER_ID:  read_mux = MAKER_ID;
            default:       read_mux = `RST_TEMP;
        endcase
    endfunction

    assign rd_data = read_mux(ptr_q);

    // Served regardless of standby: the bus side never looks at it
    always_ff @(posedge sys_clk_in)
    begin
        if (!nrst_in)
        begin
            ptr_q <= `RST_TEMP;
            config_q <= `RST_CONFIG;
            loc_hi_q <= `RST_HI_LIM;
            loc_lo_q <= `RST_LO_LIM;
            rem_hi_q <= `RST_HI_LIM;
            rem_lo_q <= `RST_LO_LIM;
            loc_th_q <= `RST_OVERTEMP_FAILSAFE_N_LIM;
            rem_th_q <= `RST_OVERTEMP_FAILSAFE_N_LIM;
            hyst_q <= `RST_HYST;
        end
        else
        begin
            if (addressed && !link.req_read)
                ptr_q <= link.req_ptr;
            if (wr_en)
            begin
                // Limits take effect at once, also in standby
                unique case (link.req_ptr)
                    `WR_CONFIG:    config_q <= link.req_data;
                    `WR_LOC_HI:    loc_hi_q <= link.req_data;
                    `WR_LOC_LO:    loc_lo_q <= link.req_data;
                    `WR_REM_HI:    rem_hi_q <= link.req_data;
                    `WR_REM_LO:    rem_lo_q <= link.req_data;
                    `RW_REM_OVERTEMP_FAILSAFE_N: rem_th_q <= link.req_data;
                    `RW_LOC_OVERTEMP_FAILSAFE_N: loc_th_q <= link.req_data;
                    `RW_HYST:      hyst_q <= link.req_data;
                    default:       ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Response and alert arbitration
    // ------------------------------------------------------------------
    // Bus shows a lower address when another device outbid us
    assign ara_won = rsp_valid_q && ara_q && link.rsp_bus == {DEV_ADDR, 1'b1};

    always_ff @(posedge sys_clk_in)
    begin
        if (!nrst_in)
        begin
            rsp_valid_q <= 1'b0;
            rsp_ack_q <= 1'b0;
            ara_q <= 1'b0;
            rsp_data_q <= `RELEASED_BYTE;
        end
        else
        begin
            rsp_valid_q <= addressed || ara_hit;
            rsp_ack_q <= addressed || ara_hit;
            ara_q <= ara_hit;
            if (ara_hit)
                rsp_data_q <= {DEV_ADDR, 1'b1};
            else if (addressed && link.req_read)
                rsp_data_q <= rd_data;
            else
                rsp_data_q <= `RELEASED_BYTE;
        end
    end

    // ------------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------------
    temp_alarm_pkg::conv_state_type state_q;
    logic [31:0] rate_cnt_q, conv_cnt_q;
    logic        shot_q, shot_pend_q, rate_tick, conv_done, abort;

    assign rate_tick = rate_cnt_q == 32'(CONV_PERIOD - 1);
    assign conv_done = state_q == temp_alarm_pkg::CONV_BUSY
                       && conv_cnt_q == 32'(CONV_LEN - 1);
    assign abort = state_q == temp_alarm_pkg::CONV_BUSY && standby && !shot_q;

    always_ff @(posedge sys_clk_in)
    begin
        if (!nrst_in)
            rate_cnt_q <= '0;
        else
            rate_cnt_q <= rate_tick ? '0 : rate_cnt_q + 32'h1;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!nrst_in)
        begin
            state_q <= temp_alarm_pkg::CONV_IDLE;
            conv_cnt_q <= '0;
            shot_q <= 1'b0;
            shot_pend_q <= 1'b0;
            open_q <= 1'b0;
            local_q <= `RST_TEMP;
            remote_q <= `RST_TEMP;
        end
        else
        begin
            if (one_shot_wr)
                shot_pend_q <= 1'b1;
            unique case (state_q)
                temp_alarm_pkg::CONV_IDLE:
                begin
                    conv_cnt_q <= '0;
                    if (shot_pend_q || (!standby && rate_tick))
                    begin
                        state_q <= temp_alarm_pkg::CONV_BUSY;
                        shot_q <= shot_pend_q;
                        shot_pend_q <= one_shot_wr;
                        open_q <= open_s2_q;
                    end
                end
                temp_alarm_pkg::CONV_BUSY:
                begin
                    conv_cnt_q <= conv_cnt_q + 32'h1;
                    if (abort)
                        state_q <= temp_alarm_pkg::CONV_IDLE;
                    else if (conv_done)
                    begin
                        state_q <= temp_alarm_pkg::CONV_IDLE;
                        local_q <= loc_s2_q;
                        remote_q <= und_s2_q ? `UNDER_RANGE_CODE : rem_s2_q;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Limit evaluation and output pins
    // ------------------------------------------------------------------
    temp_limit_check u_loc_check (
        .temp_in          (local_q),
        .hi_in            (loc_hi_q),
        .lo_in            (loc_lo_q),
        .overtemp_failsafe_n_lim_in     (loc_th_q),
        .hyst_in          (hyst_q),
        .overtemp_failsafe_n_active_in  (th_loc_q),
        .out_of_range_out (loc_oor),
        .overtemp_failsafe_n_next_out   (th_loc_d)
    );

    temp_limit_check u_rem_check (
        .temp_in          (remote_q),
        .hi_in            (rem_hi_q),
        .lo_in            (rem_lo_q),
        .overtemp_failsafe_n_lim_in     (rem_th_q),
        .hyst_in          (hyst_q),
        .overtemp_failsafe_n_active_in  (th_rem_q),
        .out_of_range_out (rem_oor),
        .overtemp_failsafe_n_next_out   (th_rem_d)
    );

    assign cond = loc_oor || rem_oor || open_q;
    assign status = {state_q == temp_alarm_pkg::CONV_BUSY, 2'b00, loc_oor, rem_oor,
                     open_q, th_rem_q, th_loc_q};

    logic alert_oe_n_q, ot_oe_n_q, busy_q;

    always_ff @(posedge sys_clk_in)
    begin
        if (!nrst_in)
        begin
            alert_q <= 1'b0;
            th_loc_q <= 1'b0;
            th_rem_q <= 1'b0;
            alert_oe_n_q <= 1'b1;
            ot_oe_n_q <= 1'b1;
            busy_q <= 1'b0;
        end
        else
        begin
            // A live condition wins over the release after an answer
            alert_q <= cond || (alert_q && !ara_won);
            th_loc_q <= th_loc_d;
            th_rem_q <= th_rem_d;
            alert_oe_n_q <= !(alert_q && !mask);
            ot_oe_n_q <= !(th_loc_q || th_rem_q);
            busy_q <= state_q == temp_alarm_pkg::CONV_BUSY;
        end
    end

    // Drive value is fixed low so the pins can only sink or float
    assign link.alert_o = 1'b0;
    assign link.alert_oe_n = alert_oe_n_q;
    assign link.overtemp_failsafe_n_o = 1'b0;
    assign link.overtemp_failsafe_n_oe_n = ot_oe_n_q;
    assign link.rsp_valid = rsp_valid_q;
    assign link.rsp_ack = rsp_ack_q;
    assign link.rsp_data = rsp_data_q;
    assign busy_out = busy_q;
endmodule

// File: temp_alarm_host.sv
// Bus master end: register access and alert response polling
`include "temp_alarm_defines.svh"
module temp_alarm_host (
    input  wire logic        sys_clk_in,
    input  wire logic        nrst_in,
    temp_alarm_if.host       link,
    input  wire logic        cmd_valid_in,
    input  wire logic        cmd_read_in,
    input  wire logic [6:0]  cmd_addr_in,
    input  wire logic [7:0]  cmd_ptr_in,
    input  wire logic        cmd_has_data_in,
    input  wire logic [7:0]  cmd_data_in,
    output logic             cmd_ready_out,
    output logic             done_out,
    output logic             ack_out,
    output logic [7:0]       rdata_out,
    output logic             alert_found_out,
    output logic [6:0]       alert_source_out,
    output logic             overtemp_n_out
);
    logic al_s1_q, al_s2_q, ot_s1_q, ot_s2_q;

    always_ff @(posedge sys_clk_in)
    begin
        al_s1_q <= link.alert_line;
        al_s2_q <= al_s1_q;
        ot_s1_q <= link.overtemp_failsafe_n_line;
        ot_s2_q <= ot_s1_q;
    end

    temp_alarm_pkg::host_state_type state_q;
    logic [3:0] cnt_q;
    logic       ara_q, req_valid_q, req_read_q, req_has_data_q, ready_q;
    logic       done_q, ack_q, found_q, ot_q;
    logic [6:0] req_addr_q, src_q;
    logic [7:0] req_ptr_q, req_data_q, rdata_q;
    logic       start_ara, start_cmd;

    // Alert polling outranks user commands while the line is low
    assign start_ara = state_q == temp_alarm_pkg::HOST_IDLE && !al_s2_q;
    assign start_cmd = state_q == temp_alarm_pkg::HOST_IDLE && al_s2_q && cmd_valid_in;

    always_ff @(posedge sys_clk_in)
    begin
        if (!nrst_in)
        begin
            state_q <= temp_alarm_pkg::HOST_IDLE;
            cnt_q <= '0;
            ara_q <= 1'b0;
            req_valid_q <= 1'b0;
            req_read_q <= 1'b0;
            req_has_data_q <= 1'b0;
            req_addr_q <= '0;
            req_ptr_q <= '0;
            req_data_q <= '0;
            done_q <= 1'b0;
            ack_q <= 1'b0;
            rdata_q <= '0;
            found_q <= 1'b0;
            src_q <= '0;
            ready_q <= 1'b0;
            ot_q <= 1'b1;
        end
        else
        begin
            req_valid_q <= start_ara || start_cmd;
            done_q <= 1'b0;
            found_q <= 1'b0;
            ot_q <= ot_s2_q;
            ready_q <= state_q == temp_alarm_pkg::HOST_IDLE && al_s2_q && !cmd_valid_in;
            unique case (state_q)
                temp_alarm_pkg::HOST_IDLE:
                begin
                    cnt_q <= '0;
                    if (start_ara)
                    begin
                        state_q <= temp_alarm_pkg::HOST_WAIT;
                        ara_q <= 1'b1;
                        req_read_q <= 1'b1;
                        req_addr_q <= `ARA_ADDR;
                        req_has_data_q <= 1'b0;
                    end
                    else if (start_cmd)
                    begin
                        state_q <= temp_alarm_pkg::HOST_WAIT;
                        ara_q <= 1'b0;
                        req_read_q <= cmd_read_in;
                        req_addr_q <= cmd_addr_in;
                        req_ptr_q <= cmd_ptr_in;
                        req_has_data_q <= cmd_has_data_in;
                        req_data_q <= cmd_data_in;
                    end
                end
                temp_alarm_pkg::HOST_WAIT:
                begin
                    cnt_q <= cnt_q + 4'h1;
                    if (link.rsp_valid || cnt_q == `HOST_TIMEOUT)
                    begin
                        ack_q <= link.rsp_valid && link.rsp_ack;
                        rdata_q <= link.rsp_bus;
                        done_q <= !ara_q;
                        found_q <= ara_q && link.rsp_valid;
                        src_q <= link.rsp_bus[7:1];
                        cnt_q <= '0;
                        // Settle time lets the released line reach the synchroniser
                        state_q <= ara_q ? temp_alarm_pkg::HOST_GAP
                                         : temp_alarm_pkg::HOST_IDLE;
                    end
                end
                temp_alarm_pkg::HOST_GAP:
                begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == `HOST_ARA_GAP)
                        state_q <= temp_alarm_pkg::HOST_IDLE;
                end
            endcase
        end
    end

    assign link.req_valid = req_valid_q;
    assign link.req_read = req_read_q;
    assign link.req_addr = req_addr_q;
    assign link.req_ptr = req_ptr_q;
    assign link.req_has_data = req_has_data_q;
    assign link.req_data = req_data_q;
    assign cmd_ready_out = ready_q;
    assign done_out = done_q;
    assign ack_out = ack_q;
    assign rdata_out = rdata_q;
    assign alert_found_out = found_q;
    assign alert_source_out = src_q;
    assign overtemp_n_out = ot_q;
endmodule

// File: temp_alarm_sva.sv
// Concurrent checks on the link between the monitor and its master
module temp_alarm_sva #(
    parameter logic [6:0] DEV_ADDR = 7'h2a
) (
    input wire logic       sys_clk_in,
    input wire logic       nrst_in,
    input wire logic       req_valid,
    input wire logic       req_read,
    input wire logic [6:0] req_addr,
    input wire logic       rsp_valid,
    input wire logic       rsp_ack,
    input wire logic [7:0] rsp_data,
    input wire logic       alert_o,
    input wire logic       alert_oe_n,
    input wire logic       overtemp_failsafe_n_o
);
    default clocking dc @(posedge sys_clk_in);
    endclocking
    default disable iff (!nrst_in);
    sequence ara_req;
        req_valid && req_read && req_addr == 7'h0c;
    endsequence
    sequence foreign_req;
        req_valid && req_addr != DEV_ADDR && req_addr != 7'h0c;
    endsequence
    alarm_drive_a: assert property (alert_o == 1'b0)
        else $error("alarm pin driven high");
    overtemp_failsafe_n_drive_a: assert property (overtemp_failsafe_n_o == 1'b0)
        else $error("overtemp pin driven high");
    ara_byte_a: assert property (ara_req |=> !rsp_valid || rsp_data == {DEV_ADDR, 1'b1})
        else $error("bad alert reply");
    // Pin lags the alarm flag by one edge, so look one edge on
    ara_silent_a: assert property (ara_req ##1 alert_oe_n |-> !rsp_valid)
        else $error("alert reply without alarm");
    own_answer_a: assert property (req_valid && req_addr == DEV_ADDR
        |=> rsp_valid && rsp_ack) else $error("own request unanswered");
    foreign_silent_a: assert property (foreign_req |=> !rsp_valid)
        else $error("foreign request answered");
    bus_released_a: assert property (!rsp_valid |-> rsp_data == 8'hff)
        else $error("reply bus not released");
    reply_cause_a: assert property (rsp_valid |-> $past(req_valid))
        else $error("reply without request");
endmodule

// File: tb_top.sv
// Self-checking bench: monitor and master joined by their link
`define CMP(nm, e, s) begin tests_run++; if ((s) !== (e)) begin err_count++; \
    $display("[FAIL] %s exp %h got %h", nm, e, s); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [6:0] DEV = 7'h2a;
    logic       sys_clk_in = 1'h0, nrst_in = 1'h0, cmd_valid_in = 1'h0, cmd_read_in = 1'h0;
    logic       cmd_has_data_in = 1'h0, remote_under_in = 1'h0, diode_open_in = 1'h0;
    logic [6:0] cmd_addr_in = 7'h00, alert_source_out;
    logic [7:0] cmd_ptr_in = 8'h00, cmd_data_in = 8'h00, adc_local_in = 8'h19, hv;
    logic [7:0] adc_remote_in = 8'h1e, rdata_out;
    logic       cmd_ready_out, done_out, ack_out, alert_found_out, overtemp_n_out, busy_out;
    logic [9:0] notes[$], note;
    logic [15:0] rst_tab[5] = '{16'h210a, 16'h0555, 16'h0800, 16'h1955, 16'h0019};
    int         err_count = 0, tests_run = 0, seed = 31;
    temp_alarm_if lnk ();
    // Short conversion counts keep the run brief
    temp_alarm_device #(.DEV_ADDR(DEV), .CONV_PERIOD(40), .CONV_LEN(10)) temp_alarm_device_inst (
        .sys_clk_in, .nrst_in, .link(lnk), .adc_local_in, .adc_remote_in, .remote_under_in,
        .diode_open_in, .busy_out);
    temp_alarm_host temp_alarm_host_inst (.sys_clk_in, .nrst_in, .link(lnk), .cmd_valid_in,
        .cmd_read_in, .cmd_addr_in, .cmd_ptr_in, .cmd_has_data_in, .cmd_data_in, .cmd_ready_out,
        .done_out, .ack_out, .rdata_out, .alert_found_out, .alert_source_out, .overtemp_n_out);
    temp_alarm_sva #(.DEV_ADDR(DEV)) temp_alarm_sva_inst (.sys_clk_in, .nrst_in,
        .req_valid(lnk.req_valid), .req_read(lnk.req_read), .req_addr(lnk.req_addr),
        .rsp_valid(lnk.rsp_valid), .rsp_ack(lnk.rsp_ack), .rsp_data(lnk.rsp_data),
        .alert_o(lnk.alert_o), .alert_oe_n(lnk.alert_oe_n),
        .overtemp_failsafe_n_o(lnk.overtemp_failsafe_n_o));
    initial
        forever #25 sys_clk_in = ~sys_clk_in;
    always @(negedge sys_clk_in)
        if (done_out === 1'b1)
        begin
            note = notes.pop_front();
            if (note[9])
                `CMP("read", note[8:0], {ack_out, rdata_out})
            else
                `CMP("ack", note[8], ack_out)
        end
    task automatic end_sim;
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Note: bit 9 asks for a data compare, bit 8 is the expected ack
    // Host re-issues a held command, so valid is one pulse after ready is seen
    task automatic cmd(input logic [24:0] c, input logic [9:0] e);
        @(negedge sys_clk_in);
        for (int n = 0; n < 2000 && cmd_ready_out !== 1'b1; n++) @(negedge sys_clk_in);
        @(posedge sys_clk_in);
        {cmd_read_in, cmd_addr_in, cmd_ptr_in, cmd_has_data_in, cmd_data_in} <= c;
        cmd_valid_in <= 1'b1;
        notes.push_back(e);
        @(posedge sys_clk_in);
        cmd_valid_in <= 1'b0;
        for (int n = 0; n < 200 && notes.size() > 0; n++) @(negedge sys_clk_in);
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        cmd({1'b0, DEV, p, 1'b1, d}, 10'h100);
    endtask
    task automatic rd(input logic [7:0] p, input logic [7:0] e);
        cmd({1'b0, DEV, p, 9'h000}, 10'h100);
        cmd({1'b1, DEV, 17'h00000}, {2'b11, e});
    endtask
    // Long enough for a full conversion plus the pin synchronisers
    task automatic env(input logic [7:0] l, input logic [1:0] f);
        @(posedge sys_clk_in);
        {adc_local_in, remote_under_in, diode_open_in} <= {l, f};
        repeat (120) @(negedge sys_clk_in);
    endtask
    task automatic alert_seen;
        for (int n = 0; n < 600 && alert_found_out !== 1'b1; n++) @(negedge sys_clk_in);
        `CMP("alert found", 1'b1, alert_found_out)
        `CMP("alert source", DEV, alert_source_out)
    endtask
    initial
    begin
        repeat (20000) @(posedge sys_clk_in);
        err_count++;
        end_sim();
    end
    initial
    begin
        repeat (6) @(posedge sys_clk_in);
        nrst_in <= 1'b1;
        alert_seen();
        foreach (rst_tab[i]) rd(rst_tab[i][15:8], rst_tab[i][7:0]);
        hv = 8'($random(seed));
        wr(8'h21, hv);
        rd(8'h21, hv);
        cmd({1'b1, 7'h33, 17'h00000}, 10'h000);
        cmd({1'b1, 7'h0c, 17'h00000}, 10'h000);
        wr(8'h0b, 8'h18);
        alert_seen();
        env(8'h14, 2'b00);
        `CMP("alarm freed", 1'b1, lnk.alert_line)
        wr(8'h0b, 8'h55);
        wr(8'h0e, 8'h80);
        env(8'h14, 2'b10);
        alert_seen();
        env(8'h14, 2'b01);
        alert_seen();
        env(8'h14, 2'b00);
        wr(8'h0b, 8'h28);
        wr(8'h20, 8'h28);
        wr(8'h21, 8'h05);
        wr(8'h09, 8'h80);
        // Above both high and over-temperature limits, so the mask has work to do
        env(8'h5a, 2'b00);
        `CMP("overtemp", 1'b0, overtemp_n_out)
        `CMP("masked alarm", 1'b1, lnk.alert_line)
        env(8'h24, 2'b00);
        `CMP("overtemp held", 1'b0, overtemp_n_out)
        env(8'h23, 2'b00);
        `CMP("overtemp freed", 1'b1, overtemp_n_out)
        wr(8'h09, 8'h40);
        env(8'h21, 2'b00);
        `CMP("busy", 1'b0, busy_out)
        rd(8'h00, 8'h23);
        cmd({1'b0, DEV, 8'h0f, 9'h000}, 10'h100);
        env(8'h21, 2'b00);
        rd(8'h00, 8'h21);
        wr(8'h0c, 8'h21);
        alert_seen();
        end_sim();
    end
endmodule
